// ===== verilog/irqrc_regs.sv
// Peripheral interrupt flag register, power control register and their interrupt logic.
// Assumes event inputs are one-cycle pulses synchronous to clk_i, except the comparator
// outputs and the mirrored peripheral flags, which are levels.
//
// Contract
// R1 - Comparator-2 flag sets on any output change, stays until software writes 0.
// R2 - In capture mode the capture/compare flag sets when timer-1 count is captured.
// R3 - In compare mode the capture/compare flag sets on timer-1 compare match.
// R4 - Status bits tell power-on, brown-out, watchdog and external pin resets apart.
// R5 - Power control register holds a software-writable brown-out reset enable.
// R6 - Flags set on their event regardless of any enable or global enable bit.
// R7 - Brown-out enable bit at one enables brown-out reset, zero disables it.
// R8 - Power-on and brown-out bits clear on their reset; software writes one after.
// R9 - Oscillator-fail flag sets on oscillator failure; unimplemented bits read zero.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/10ps
`include "irqrc_defines.svh"

module irqrc_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic osc_fail_i,
  input wire logic comparator2_output_i,
  input wire logic comparator1_change_flag_i,
  input wire logic display_driver_flag_i,
  input wire logic low_voltage_i,
  input wire logic [1:0] capcmp2_mode_i,
  input wire logic capcmp2_capture_i,
  input wire logic capcmp2_match_i,
  input wire logic brownout_reset_i,
  input wire logic watchdog_timeout_i,
  input wire logic external_reset_pin_i,
  output logic brownout_reset_en_o,
  output logic irq_o
);

  irqrc_pkg::irqrc_state_t s_r;
  irqrc_pkg::irqrc_state_t s_nxt;
  logic req;
  logic wr;
  logic [7:0] ev;
  logic [7:0] wbyte;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // One compare serves every register write, so a new offset needs only a new define.
  function automatic logic addr_hit(input logic [11:0] adr, input logic [11:0] reg_adr);
    return adr == reg_adr;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    req = wb_cyc_i && wb_stb_i && !s_r.ack;
    wr = req && wb_we_i && wb_sel_i[0];
    wbyte = wb_dat_i[7:0];
    ev = 8'h00;
    // Events are taken without looking at mask or any enable.  see R6
    ev[`IRQRC_OSC_BIT] = osc_fail_i; // see R9
    ev[`IRQRC_C2_BIT] = comparator2_output_i ^ s_r.c2_prev; // see R1
    ev[`IRQRC_C1_BIT] = comparator1_change_flag_i;
    ev[`IRQRC_LCD_BIT] = display_driver_flag_i;
    ev[`IRQRC_LVD_BIT] = low_voltage_i;
    ev[`IRQRC_CCP_BIT] =
      (capcmp2_mode_i == irqrc_pkg::IRQRC_CCP_CAPTURE && capcmp2_capture_i) || // see R2
      (capcmp2_mode_i == irqrc_pkg::IRQRC_CCP_COMPARE && capcmp2_match_i); // see R3
    s_nxt.c2_prev = comparator2_output_i;
    s_nxt.ack = req;

    // Writing zero clears a flag; an event in the same cycle wins.  see R1
    if (wr && addr_hit(wb_adr_i, `IRQRC_FLAGS_ADDR)) begin
      s_nxt.flags = s_r.flags & (wbyte | ~`IRQRC_FLAGS_WMASK);
    end
    s_nxt.flags = (s_nxt.flags | ev) & `IRQRC_FLAGS_WMASK; // see R9
    // Read-only bits mirror the peripheral's own flag.
    s_nxt.flags[`IRQRC_C1_BIT] = comparator1_change_flag_i;
    s_nxt.flags[`IRQRC_LCD_BIT] = display_driver_flag_i;

    if (wr && addr_hit(wb_adr_i, `IRQRC_POWER_CONTROL_REG_ADDR)) begin
      s_nxt.sbor_en = wbyte[`IRQRC_SBOR_BIT]; // see R5
      s_nxt.por_n = wbyte[`IRQRC_POR_BIT]; // see R8
      s_nxt.bor_n = wbyte[`IRQRC_BOR_BIT]; // see R8
    end
    // A brown-out only counts while it is enabled; it beats a write.  see R7
    if (brownout_reset_i && s_r.sbor_en) begin
      s_nxt.bor_n = 1'b0; // see R8
    end

    if (wr && addr_hit(wb_adr_i, `IRQRC_CAUSE_ADDR)) begin
      s_nxt.cause = s_r.cause & ~wbyte[1:0];
    end
    s_nxt.cause[`IRQRC_WDT_BIT] = s_nxt.cause[`IRQRC_WDT_BIT] | watchdog_timeout_i; // see R4
    s_nxt.cause[`IRQRC_PIN_BIT] = s_nxt.cause[`IRQRC_PIN_BIT] | external_reset_pin_i; // see R4

    if (wr && addr_hit(wb_adr_i, `IRQRC_STATUS_ADDR)) begin
      s_nxt.status = s_r.status & ~wbyte;
    end
    s_nxt.status = (s_nxt.status | ev) & 8'hf5;
    if (wr && addr_hit(wb_adr_i, `IRQRC_MASK_ADDR)) begin
      s_nxt.mask = wbyte & 8'hf5;
    end
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);

    // Read data is captured with the request so it reaches the bus from a flop.
    s_nxt.rdata = 32'h0000_0000;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        `IRQRC_FLAGS_ADDR: s_nxt.rdata[7:0] = s_r.flags;
        `IRQRC_POWER_CONTROL_REG_ADDR: begin
          s_nxt.rdata[`IRQRC_SBOR_BIT] = s_r.sbor_en;
          s_nxt.rdata[`IRQRC_POR_BIT] = s_r.por_n; // see R4
          s_nxt.rdata[`IRQRC_BOR_BIT] = s_r.bor_n; // see R4
        end
        `IRQRC_CAUSE_ADDR: s_nxt.rdata[1:0] = s_r.cause;
        `IRQRC_STATUS_ADDR: s_nxt.rdata[7:0] = s_r.status;
        `IRQRC_MASK_ADDR: s_nxt.rdata[7:0] = s_r.mask;
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset is the power-on event, so it clears the power-on bit.  see R8
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r.flags <= `IRQRC_FLAGS_RST;
      s_r.sbor_en <= `IRQRC_SBOR_RST;
      s_r.por_n <= `IRQRC_POR_RST;
      s_r.bor_n <= `IRQRC_BOR_RST;
      s_r.cause <= `IRQRC_CAUSE_RST;
      s_r.status <= `IRQRC_STATUS_RST;
      s_r.mask <= `IRQRC_MASK_RST;
      s_r.c2_prev <= 1'b0;
      s_r.ack <= 1'b0;
      s_r.rdata <= 32'h0000_0000;
      s_r.irq <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.rdata;
  assign wb_ack_o = s_r.ack;
  assign brownout_reset_en_o = s_r.sbor_en; // see R7
  assign irq_o = s_r.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  c2_change_sets_a: assert property ( // see R1
    $changed(comparator2_output_i) |=> s_r.flags[`IRQRC_C2_BIT])
    else $error("comparator-2 change did not set its flag");
  c2_flag_holds_a: assert property ( // see R1
    s_r.flags[`IRQRC_C2_BIT] && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> s_r.flags[`IRQRC_C2_BIT])
    else $error("comparator-2 flag dropped without a write");
  capture_sets_a: assert property ( // see R2
    capcmp2_mode_i == irqrc_pkg::IRQRC_CCP_CAPTURE && capcmp2_capture_i
      |=> s_r.flags[`IRQRC_CCP_BIT])
    else $error("capture did not set the capture/compare flag");
  compare_sets_a: assert property ( // see R3
    capcmp2_mode_i == irqrc_pkg::IRQRC_CCP_COMPARE && capcmp2_match_i
      |=> s_r.flags[`IRQRC_CCP_BIT])
    else $error("compare match did not set the capture/compare flag");
  cause_bits_a: assert property ( // see R4
    watchdog_timeout_i |=> s_r.cause[`IRQRC_WDT_BIT])
    else $error("watchdog reset cause not recorded");
  pin_cause_a: assert property ( // see R4
    external_reset_pin_i |=> s_r.cause[`IRQRC_PIN_BIT])
    else $error("external pin reset cause not recorded");
  sbor_write_a: assert property ( // see R5
    wr && wb_adr_i == `IRQRC_POWER_CONTROL_REG_ADDR |=> brownout_reset_en_o == $past(wb_dat_i[4]))
    else $error("brown-out enable write not taken");
  bor_gated_a: assert property ( // see R7
    brownout_reset_i && !brownout_reset_en_o && !wr |=> s_r.bor_n == $past(s_r.bor_n))
    else $error("disabled brown-out changed its status bit");
  bor_clears_a: assert property ( // see R8
    brownout_reset_i && brownout_reset_en_o |=> !s_r.bor_n ##1 1'b1)
    else $error("brown-out did not clear its status bit");
  osc_fail_a: assert property ( // see R9
    osc_fail_i |=> s_r.flags[`IRQRC_OSC_BIT] && s_r.flags[3] == 1'b0 && s_r.flags[1] == 1'b0)
    else $error("oscillator fail flag or reserved bits wrong");
  event_no_mask_a: assert property ( // see R6
    low_voltage_i && s_r.mask == 8'h00 |=> s_r.flags[`IRQRC_LVD_BIT] && s_r.status[2] && !irq_o)
    else $error("masked event lost or raised the interrupt");
  ack_one_cycle_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack stood for more than one cycle");
  // Read data must be zero between answers, so a stale value cannot be mistaken for a read.
  rdata_idle_a: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside an answer");
  mirror_c1_a: assert property (
    comparator1_change_flag_i |=> s_r.flags[`IRQRC_C1_BIT])
    else $error("comparator-1 mirror bit not set");
  mirror_lcd_a: assert property (
    display_driver_flag_i |=> s_r.flags[`IRQRC_LCD_BIT])
    else $error("display mirror bit not set");
  reserved_zero_a: assert property ( // see R9
    s_r.flags[3] == 1'b0 && s_r.flags[1] == 1'b0 && s_r.status[3] == 1'b0)
    else $error("unimplemented bit read as one");
  irq_level_a: assert property ( // see R6
    irq_o == |(s_r.status & s_r.mask))
    else $error("interrupt level disagrees with status and mask");

  cov_irq_c: cover property (s_r.status[`IRQRC_C2_BIT] && s_r.mask[`IRQRC_C2_BIT] ##1 irq_o);
  cov_clear_c: cover property (s_r.flags[`IRQRC_CCP_BIT] ##[1:20] !s_r.flags[`IRQRC_CCP_BIT]);
  cov_bor_c: cover property (brownout_reset_i && brownout_reset_en_o);
  cov_race_c: cover property (wr && wb_adr_i == `IRQRC_FLAGS_ADDR && osc_fail_i);

endmodule

// ===== inc/irqrc_defines.svh
// Register offsets, field positions, reset values and masks of the flag and reset-cause bank.
// Assumes a 32-bit classic Wishbone slave port with a byte address.
`ifndef IRQRC_DEFINES_SVH
`define IRQRC_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define IRQRC_FLAGS_IDX 12'h00d
`define IRQRC_POWER_CONTROL_REG_IDX 12'h08e
`define IRQRC_CAUSE_IDX 12'h0a0
`define IRQRC_STATUS_IDX 12'h0a1
`define IRQRC_MASK_IDX 12'h0a2
`define IRQRC_FLAGS_ADDR (`IRQRC_FLAGS_IDX << 2)
`define IRQRC_POWER_CONTROL_REG_ADDR (`IRQRC_POWER_CONTROL_REG_IDX << 2)
`define IRQRC_CAUSE_ADDR (`IRQRC_CAUSE_IDX << 2)
`define IRQRC_STATUS_ADDR (`IRQRC_STATUS_IDX << 2)
`define IRQRC_MASK_ADDR (`IRQRC_MASK_IDX << 2)

// ----------------------------------------------------------------
// Flag register fields
// ----------------------------------------------------------------
`define IRQRC_OSC_BIT 7
`define IRQRC_C2_BIT 6
`define IRQRC_C1_BIT 5
`define IRQRC_LCD_BIT 4
`define IRQRC_LVD_BIT 2
`define IRQRC_CCP_BIT 0
`define IRQRC_FLAGS_WMASK 8'hc5
`define IRQRC_FLAGS_RST 8'h00

// ----------------------------------------------------------------
// Power control and reset-cause fields
// ----------------------------------------------------------------
`define IRQRC_SBOR_BIT 4
`define IRQRC_POR_BIT 1
`define IRQRC_BOR_BIT 0
`define IRQRC_SBOR_RST 1'b1
`define IRQRC_POR_RST 1'b0
`define IRQRC_BOR_RST 1'b1
`define IRQRC_WDT_BIT 0
`define IRQRC_PIN_BIT 1
`define IRQRC_CAUSE_RST 2'h0
`define IRQRC_STATUS_RST 8'h00
`define IRQRC_MASK_RST 8'h00

`endif

// ===== inc/irqrc_pkg.sv
// Types shared by the flag and reset-cause bank.
// Assumes the defines header supplies every number but the capture/compare mode encodings.
package irqrc_pkg;

  // Operating mode of the second capture/compare unit.
  typedef enum logic [1:0] {
    IRQRC_CCP_OFF = 2'h0,
    IRQRC_CCP_CAPTURE = 2'h1,
    IRQRC_CCP_COMPARE = 2'h2,
    IRQRC_CCP_PWM = 2'h3
  } irqrc_ccp_mode_t;

  // All state of the register bank.
  typedef struct packed {
    logic [7:0] flags;
    logic sbor_en;
    logic por_n;
    logic bor_n;
    logic [1:0] cause;
    logic [7:0] status;
    logic [7:0] mask;
    logic c2_prev;
    logic ack;
    logic [31:0] rdata;
    logic irq;
  } irqrc_state_t;

endpackage

// ===== verif/irqrc_regs_bench.sv
// Self-checking bench for the flag and reset-cause register bank.
// Assumes a Wishbone answer within 20 cycles and one-cycle event pulses.
`timescale 1ns/10ps
`include "irqrc_defines.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED at %0t got %h exp %h", $time, a, e); end end

module irqrc_regs_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat = 32'h0, q, dat_o;
  logic ack, irq, bor_en;
  logic osc = 0, c2 = 0, c1 = 0, disp = 0, lvd = 0, cap = 0, mat = 0, bor = 0, wdt = 0, pin = 0;
  logic [1:0] mode = 2'h0;
  logic [7:0] fl, st, mk, pc, ca, rnd;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  localparam logic [11:0] F = 12'(`IRQRC_FLAGS_ADDR), P = 12'(`IRQRC_POWER_CONTROL_REG_ADDR);
  localparam logic [11:0] C = 12'(`IRQRC_CAUSE_ADDR), S = 12'(`IRQRC_STATUS_ADDR);
  localparam logic [11:0] M = 12'(`IRQRC_MASK_ADDR);

  irqrc_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .osc_fail_i(osc), .comparator2_output_i(c2), .comparator1_change_flag_i(c1),
    .display_driver_flag_i(disp), .low_voltage_i(lvd), .capcmp2_mode_i(mode),
    .capcmp2_capture_i(cap), .capcmp2_match_i(mat), .brownout_reset_i(bor),
    .watchdog_timeout_i(wdt), .external_reset_pin_i(pin), .brownout_reset_en_o(bor_en),
    .irq_o(irq));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // The whole run needs under two hundred cycles, so a hang is cut off at 4000 cycles.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      give_verdict();
    end
  end

  // --------------------------------------------------------
  // Model and bus tasks
  // --------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d};
    do begin
      @(posedge clk_i); #1; t++;
    end while (ack !== 1'b1 && t < 20);
    if (ack !== 1'b1) begin
      errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, ack, 1'b1);
    end
    q = dat_o;
    @(posedge clk_i);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(q, {24'h0, e})
    `CHK(irq, |(st & mk))
  endtask

  // Bits of v: osc fail, comparator toggle, low voltage, capture, match, brown-out,
  // watchdog, pin.
  task automatic ev(input logic [7:0] v);
    logic [7:0] e;
    @(posedge clk_i);
    osc <= v[7]; c2 <= c2 ^ v[6]; lvd <= v[5]; cap <= v[4]; mat <= v[3];
    bor <= v[2]; wdt <= v[1]; pin <= v[0];
    @(posedge clk_i);
    {osc, lvd, cap, mat, bor, wdt, pin} <= 7'h00;
    e = {v[7], v[6], 3'h0, v[5], 1'b0, (v[4] && mode == 2'h1) || (v[3] && mode == 2'h2)};
    fl = fl | e;
    st = st | e;
    if (v[2] && pc[4]) pc[0] = 1'b0;
    ca = ca | {6'h0, v[0], v[1]};
    rd(F, fl);
  endtask

  // --------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------
  initial begin
    rnd = 8'h1a; fl = 8'h00; st = 8'h00; mk = 8'h00; pc = 8'h11; ca = 8'h00;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(F, 8'h00);
    rd(P, 8'h11);
    rd(C, 8'h00);
    rd(S, 8'h00);
    rd(M, 8'h00);
    rd(12'h004, 8'h00);
    `CHK(bor_en, 1'b1)
    $display("test reset done");
    mode <= 2'h2;
    ev(8'h10);
    ev(8'h08);
    bus(1'b1, F, 8'hfe); fl = fl & 8'hfe; rd(F, fl);
    mode <= 2'h1;
    ev(8'h08);
    ev(8'h10);
    bus(1'b1, F, 8'h00); fl = 8'h00; mode <= 2'h3;
    ev(8'h18);
    ev(8'h80);
    ev(8'h20);
    ev(8'h40);
    bus(1'b1, F, 8'hbf); fl = fl & 8'hbf; rd(F, fl);
    ev(8'h40);
    $display("test flags done");
    rnd = lfsr(rnd); mk = (rnd & 8'hc5) | 8'h80;
    bus(1'b1, M, mk); rd(M, mk);
    bus(1'b1, S, st); st = 8'h00; rd(S, 8'h00);
    ev(8'h80);
    bus(1'b1, M, 8'h00); mk = 8'h00; rd(M, 8'h00);
    $display("test interrupt done");
    bus(1'b1, P, 8'h03); pc = 8'h03; rd(P, pc);
    `CHK(bor_en, 1'b0)
    ev(8'h04); rd(P, pc);
    bus(1'b1, P, 8'h13); pc = 8'h13; ev(8'h04); rd(P, 8'h12);
    bus(1'b1, P, 8'h13); pc = 8'h13; rd(P, 8'h13);
    `CHK(bor_en, 1'b1)
    ev(8'h02); ev(8'h01); rd(C, 8'h03);
    bus(1'b1, C, 8'h01); ca = 8'h02; rd(C, ca);
    $display("test reset cause done");
    rnd = lfsr(rnd); c1 <= rnd[0]; disp <= rnd[1];
    rd(F, fl | {2'h0, rnd[0], rnd[1], 4'h0});
    $display("test mirrors done");
    give_verdict();
  end
endmodule
